// *** hw/lss_consts.vh ***
// constants for the indicator source select block
`ifndef LSS_CONSTS_VH
`define LSS_CONSTS_VH
// register map (byte addresses of the configuration and status registers)
`define LSS_ADDR_CFG      12'h014
`define LSS_ADDR_STATUS   12'h018
// configuration field positions
`define LSS_F1_HI         15
`define LSS_F1_LO         12
`define LSS_F2_HI         11
`define LSS_F2_LO         8
`define LSS_LEN_HI        3
`define LSS_LEN_LO        2
`define LSS_STRETCH_BIT   1
// reset value: first 0000, second 0100, length 00, stretch on
`define LSS_CFG_RESET     16'h0422
`define LSS_CFG_WMASK     16'hfffe
// source codes
`define LSS_SRC_SPEED     4'h0
`define LSS_SRC_TX        4'h1
`define LSS_SRC_RX        4'h2
`define LSS_SRC_COL       4'h3
`define LSS_SRC_LINK      4'h4
`define LSS_SRC_DUPLEX    4'h5
`define LSS_SRC_UNUSED6   4'h6
`define LSS_SRC_ACT       4'h7
`define LSS_SRC_ON        4'h8
`define LSS_SRC_OFF       4'h9
`define LSS_SRC_FAST      4'ha
`define LSS_SRC_SLOW      4'hb
`define LSS_SRC_LINKRX    4'hc
`define LSS_SRC_DUPCOL    4'hd
`define LSS_SRC_LINKACT   4'he
`define LSS_SRC_UNUSED15  4'hf
// stretch times in ms and cycles at 125 MHz
`define LSS_CLK_KHZ       125000
`define LSS_T0_MS         30
`define LSS_T1_MS         60
`define LSS_T2_MS         100
`define LSS_CNT_W         24
// blink half periods in ms
`define LSS_FAST_MS       50
`define LSS_SLOW_MS       250
`endif

// *** hw/lss_stretch.v ***
// retriggerable pulse stretcher for one indicator event
`include "lss_consts.vh"
module lss_stretch (
    // clock and reset
    input  wire                   mclk,
    input  wire                   rst_n,
    input  wire                   clkEn,
    // control
    input  wire                   enable,
    input  wire [`LSS_CNT_W-1:0]  holdCycles,
    // event in, stretched out
    input  wire                   trigger,
    output reg                    stretched
);
    reg [`LSS_CNT_W-1:0] remain;   // cycles left to hold

    // reload on every event; hold until count runs out
    always @(posedge mclk) begin
        if (!rst_n) begin
            remain    <= {`LSS_CNT_W{1'b0}};
            stretched <= 1'b0;
        end else if (clkEn) begin
            if (!enable) begin
                // pass through unstretched
                remain    <= {`LSS_CNT_W{1'b0}};
                stretched <= trigger;
            end else if (trigger) begin
                remain    <= holdCycles;
                stretched <= 1'b1;
            end else if (remain != {`LSS_CNT_W{1'b0}}) begin
                remain    <= remain - {{(`LSS_CNT_W-1){1'b0}}, 1'b1};
                stretched <= 1'b1;
            end else begin
                stretched <= 1'b0;
            end
        end
    end
endmodule // lss_stretch

// *** hw/lss_led_source_select.v ***
// indicator source select with APB configuration register
//
// Functional notes
// - first select bits 15:12, reset speed
// - second select bits 11:8, reset link
// - codes 1 transmit, 2 receive, stretched
// - codes 3 collision, 4 link, 5 duplex
// - code 7 shows receive or transmit activity
// - code 8 forced on, 9 forced off
// - code 10 fast blink, 11 slow
// - second: 12 link+receive, 13 duplex+collision
// - first also offers link+activity, stretched
// - link solid on, event toggles blink
// - activity blinks even with link down
// - full duplex solid, collision toggles
// - combined modes always stretch events
// - level and test modes never stretched
// - bit 1 enables stretching, resets enabled
// - length field 30/60/100 ms, 11 reserved
`include "lss_consts.vh"
module lss_led_source_select #(
    parameter FAST_HALF = (`LSS_FAST_MS * `LSS_CLK_KHZ),  // fast blink half period
    parameter SLOW_HALF = (`LSS_SLOW_MS * `LSS_CLK_KHZ)   // slow blink half period
) (
    // clock, reset, enable
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        clkEn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // transceiver core status, same clock
    input  wire        linkUp,
    input  wire        speed100,
    input  wire        fullDuplex,
    input  wire        txActive,
    input  wire        rxActive,
    input  wire        collision,
    // indicator outputs, active high
    output reg         firstIndicator,
    output reg         secondIndicator
);
    // first select is not decoded alike: second lacks code 14, adds nothing else
    localparam [1:0] IDX_FIRST  = 2'b01;   // one-hot index of first indicator
    localparam [1:0] IDX_SECOND = 2'b10;   // one-hot index of second indicator

    reg  [15:0] cfg;                        // configuration register
    wire [3:0]  firstSel  = cfg[`LSS_F1_HI:`LSS_F1_LO];
    wire [3:0]  secondSel = cfg[`LSS_F2_HI:`LSS_F2_LO];
    wire [1:0]  lenSel    = cfg[`LSS_LEN_HI:`LSS_LEN_LO];
    wire        stretchOn = cfg[`LSS_STRETCH_BIT];

    // apb decode: zero wait states, unmapped address reports an error
    wire access  = psel & penable;
    wire hitCfg  = (paddr == `LSS_ADDR_CFG);
    wire hitStat = (paddr == `LSS_ADDR_STATUS);
    assign pready  = 1'b1;
    assign pslverr = access & ~hitCfg & ~hitStat;

    // hold times worked out at full width, then cut to the counter width on purpose
    localparam [31:0] HOLD_T0 = `LSS_T0_MS * `LSS_CLK_KHZ;   // shortest stretch
    localparam [31:0] HOLD_T1 = `LSS_T1_MS * `LSS_CLK_KHZ;   // middle stretch
    localparam [31:0] HOLD_T2 = `LSS_T2_MS * `LSS_CLK_KHZ;   // longest stretch

    // stretch length in cycles; reserved code falls back to longest
    function [`LSS_CNT_W-1:0] lenCycles;
        input [1:0] sel;
        begin
            case (sel)
                2'b00:   lenCycles = HOLD_T0[`LSS_CNT_W-1:0];
                2'b01:   lenCycles = HOLD_T1[`LSS_CNT_W-1:0];
                default: lenCycles = HOLD_T2[`LSS_CNT_W-1:0];
            endcase
        end
    endfunction
    wire [`LSS_CNT_W-1:0] holdCycles = lenCycles(lenSel);

    // register write; reset value puts speed on first, link on second
    always @(posedge mclk) begin
        if (!rst_n) begin
            cfg <= `LSS_CFG_RESET;
        end else if (clkEn && access && pwrite && hitCfg) begin
            cfg <= pwdata[15:0] & `LSS_CFG_WMASK; // reserved bit 0 stays zero
        end
    end

    // read data registered from the setup phase so it is ready at access
    always @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (clkEn && psel && !penable) begin
            if (paddr == `LSS_ADDR_CFG) begin
                prdata <= {16'h0000, cfg};
            end else if (paddr == `LSS_ADDR_STATUS) begin
                // live state of the indicators and their inputs
                prdata <= {24'h00_0000, secondIndicator, firstIndicator, collision,
                           rxActive, txActive, fullDuplex, speed100, linkUp};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // blink timers: free-running toggles for the test patterns
    reg [31:0] fastCnt;
    reg [31:0] slowCnt;
    reg        fastBlink;
    reg        slowBlink;
    always @(posedge mclk) begin
        if (!rst_n) begin
            fastCnt   <= 32'h0000_0000;
            slowCnt   <= 32'h0000_0000;
            fastBlink <= 1'b0;
            slowBlink <= 1'b0;
        end else if (clkEn) begin
            if (fastCnt >= FAST_HALF - 1) begin
                fastCnt   <= 32'h0000_0000;
                fastBlink <= ~fastBlink;
            end else begin
                fastCnt <= fastCnt + 32'h0000_0001;
            end
            if (slowCnt >= SLOW_HALF - 1) begin
                slowCnt   <= 32'h0000_0000;
                slowBlink <= ~slowBlink;
            end else begin
                slowCnt <= slowCnt + 32'h0000_0001;
            end
        end
    end

    // event sources that are stretched: index 0 tx, 1 rx, 2 col, 3 activity
    wire [3:0] rawEvent = {txActive | rxActive, collision, rxActive, txActive};
    wire [3:0] stEvent;      // stretched per global enable
    wire [3:0] forcedEvent;  // always stretched, used by combined modes
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gStretch
            // global enable governs plain event displays
            lss_stretch uSt (
                .mclk       (mclk),
                .rst_n      (rst_n),
                .clkEn      (clkEn),
                .enable     (stretchOn),
                .holdCycles (holdCycles),
                .trigger    (rawEvent[g]),
                .stretched  (stEvent[g])
            );
            // combined modes ignore the enable bit
            lss_stretch uFc (
                .mclk       (mclk),
                .rst_n      (rst_n),
                .clkEn      (clkEn),
                .enable     (1'b1),
                .holdCycles (holdCycles),
                .trigger    (rawEvent[g]),
                .stretched  (forcedEvent[g])
            );
        end
    endgenerate

    // combined blink: while a stretched event lasts, the phase flips the lamp
    // a register that copies the fast timer toggle gives a visible blink
    reg [1:0] comboPhase;
    always @(posedge mclk) begin
        if (!rst_n) begin
            comboPhase <= 2'b00;
        end else if (clkEn) begin
            // copies fastBlink every enabled cycle, whether or not an event is stretched
            comboPhase <= {fastBlink, fastBlink};
        end
    end

    // one decoder shared by both indicators; which = one-hot indicator index
    function decodeSource;
        input [3:0] sel;
        input [1:0] which;
        input [3:0] ev;
        input [3:0] fev;
        input       link;
        input       spd;
        input       dup;
        input       fast;
        input       slow;
        input       phase;
        begin
            case (sel)
                `LSS_SRC_SPEED:   decodeSource = spd;
                `LSS_SRC_TX:      decodeSource = ev[0];
                `LSS_SRC_RX:      decodeSource = ev[1];
                `LSS_SRC_COL:     decodeSource = ev[2];
                `LSS_SRC_LINK:    decodeSource = link;
                `LSS_SRC_DUPLEX:  decodeSource = dup;
                `LSS_SRC_ACT:     decodeSource = ev[3];
                `LSS_SRC_ON:      decodeSource = 1'b1;
                `LSS_SRC_OFF:     decodeSource = 1'b0;
                `LSS_SRC_FAST:    decodeSource = fast;
                `LSS_SRC_SLOW:    decodeSource = slow;
                // link solid, stretched receive inverts it; link down still blinks
                `LSS_SRC_LINKRX:  decodeSource = link ^ (fev[1] & phase);
                // full duplex solid, stretched collision inverts it
                `LSS_SRC_DUPCOL:  decodeSource = dup ^ (fev[2] & phase);
                // link plus activity only exists on the first indicator
                `LSS_SRC_LINKACT: decodeSource = (which == IDX_FIRST) ?
                                                 (link ^ (fev[3] & phase)) : 1'b0;
                // unused codes show nothing; software must avoid them
                default:          decodeSource = 1'b0;
            endcase
        end
    endfunction

    // indicator output flops
    always @(posedge mclk) begin
        if (!rst_n) begin
            firstIndicator  <= 1'b0;
            secondIndicator <= 1'b0;
        end else if (clkEn) begin
            firstIndicator  <= decodeSource(firstSel, IDX_FIRST, stEvent, forcedEvent,
                                            linkUp, speed100, fullDuplex,
                                            fastBlink, slowBlink, comboPhase[0]);
            // second's code 6 falls to default as unused
            secondIndicator <= decodeSource(secondSel, IDX_SECOND, stEvent, forcedEvent,
                                            linkUp, speed100, fullDuplex,
                                            fastBlink, slowBlink, comboPhase[1]);
        end
    end
endmodule // lss_led_source_select

// *** verification/lss_asserts.sv ***
// concurrent checks on the indicator select ports
`include "lss_consts.vh"
module lss_asserts (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        clkEn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // status and lamps
    input wire logic        linkUp,
    input wire logic        speed100,
    input wire logic        txActive,
    input wire logic        firstIndicator,
    input wire logic        secondIndicator
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] shadow;                // configuration rebuilt from apb writes
    wire  [3:0]  f1 = shadow[15:12];    // first select
    wire  [3:0]  f2 = shadow[11:8];     // second select
    wire         st = shadow[1];        // stretch enable
    wire         tx1 = clkEn && f1 == `LSS_SRC_TX && st;
    // mirror the register, since the lamp checks need the selected source
    always_ff @(posedge mclk) begin
        if (!rst_n)
            shadow <= `LSS_CFG_RESET;
        else if (psel && penable && pwrite && clkEn && paddr == `LSS_ADDR_CFG)
            shadow <= pwdata[15:0] & `LSS_CFG_WMASK;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_speed_shown: assert property (clkEn && f1 == `LSS_SRC_SPEED |=>
        firstIndicator == $past(speed100)) else $error("first lamp not speed");
    a_link_shown: assert property (clkEn && f2 == `LSS_SRC_LINK |=>
        secondIndicator == $past(linkUp)) else $error("second lamp not link");
    a_forced_on: assert property (clkEn && f1 == `LSS_SRC_ON |=> firstIndicator)
        else $error("forced on lamp dark");
    // unstretched events pass the stretcher flop and then the lamp flop: two cycles
    a_tx_direct: assert property (clkEn && $past(clkEn) && f1 == `LSS_SRC_TX && !st &&
        !$past(st) |=> firstIndicator == $past(txActive, 2)) else $error("unstretched tx wrong");
    a_tx_held: assert property (tx1 && txActive ##1 tx1[*4] |-> firstIndicator)
        else $error("stretched tx dropped");
    a_unused_off: assert property (clkEn && f1 == `LSS_SRC_UNUSED15 |=>
        !firstIndicator) else $error("unused code lit lamp");
    a_ready_err: assert property (psel && penable |-> pready && pslverr ==
        (paddr != `LSS_ADDR_CFG && paddr != `LSS_ADDR_STATUS)) else $error("bad response");
    a_cfg_read: assert property (psel && !penable && !pwrite && clkEn &&
        paddr == `LSS_ADDR_CFG |=> prdata == {16'h0000, shadow}) else $error("bad readback");
    c_stretch: cover property (tx1 && $fell(txActive));
    c_error: cover property (psel && penable && pslverr);
    c_combined: cover property (f2 == `LSS_SRC_LINKRX && $changed(secondIndicator));
endmodule // lss_asserts

bind lss_led_source_select lss_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .linkUp(linkUp),
    .speed100(speed100), .txActive(txActive), .firstIndicator(firstIndicator),
    .secondIndicator(secondIndicator));

// *** verification/lss_lamp_model.sv ***
// lamp model that counts how often an indicator changes state
module lss_lamp_model (
    // clock and control
    input  wire logic        mclk,
    input  wire logic        clear,
    // lamp drive, high lights it
    input  wire logic        lamp,
    // changes seen since the last clear
    output logic      [15:0] toggles
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lastLamp;  // level at the previous edge
    // an eye only sees level changes, so those are what we count
    always_ff @(posedge mclk) begin
        lastLamp <= lamp;
        if (clear)
            toggles <= 16'h0000;
        else if (lamp !== lastLamp)
            toggles <= toggles + 16'h0001;
    end
endmodule // lss_lamp_model

// *** verification/led_source_select_tb.sv ***
// self-checking bench for the indicator source select block
`include "lss_consts.vh"
module led_source_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] YES = 32'h0000_0001;
    logic        mclk, rst_n, clkEn, psel, penable, pwrite, pready, pslverr, clr, look;
    logic        linkUp, speed100, fullDuplex, txActive, rxActive, collision;
    logic        firstIndicator, secondIndicator;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] togA, togB;                // lamp changes seen by the models
    logic [3:0]  f;
    logic [3:0]  codes [0:10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                                  4'h9, 4'hf};
    logic [31:0] expQ [$];                  // expected results, oldest first
    int          errors, checked, seed, k;
    lss_led_source_select #(.FAST_HALF(4), .SLOW_HALF(16)) DUT (.mclk(mclk), .rst_n(rst_n),
        .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .linkUp(linkUp), .speed100(speed100), .fullDuplex(fullDuplex), .txActive(txActive),
        .rxActive(rxActive), .collision(collision), .firstIndicator(firstIndicator),
        .secondIndicator(secondIndicator));
    lss_lamp_model u_lampA (.mclk(mclk), .clear(clr), .lamp(firstIndicator), .toggles(togA));
    lss_lamp_model u_lampB (.mclk(mclk), .clear(clr), .lamp(secondIndicator), .toggles(togB));
    // free running clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // apb transfer; the caller queues read data beforehand
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        {psel, penable} <= 2'b00;
        if (k == 50) errors++;
        if (k == 50) finish_test;
    endtask
    // queue a lamp note and flag the monitor to sample at the next edge
    task automatic lamps(input logic [1:0] want);
        expQ.push_back({30'h0, want});
        look <= 1'b1;
        @(posedge mclk);
        look <= 1'b0;
    endtask
    // clear the lamp models and let n cycles pass
    task automatic watch(input int n);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask
    task automatic doReset;
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
    endtask
    // level a plain source code should show, with stretching off
    function automatic logic lvl(input logic [3:0] c);
        case (c)
            `LSS_SRC_SPEED:  lvl = speed100;
            `LSS_SRC_TX:     lvl = txActive;
            `LSS_SRC_RX:     lvl = rxActive;
            `LSS_SRC_COL:    lvl = collision;
            `LSS_SRC_LINK:   lvl = linkUp;
            `LSS_SRC_DUPLEX: lvl = fullDuplex;
            `LSS_SRC_ACT:    lvl = txActive | rxActive;
            `LSS_SRC_ON:     lvl = 1'b1;
            default:         lvl = 1'b0;                    // forced off and unused codes
        endcase
    endfunction
    // monitor: each finished read or lamp sample takes the oldest note
    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite)
            check(prdata, expQ.pop_front());
        if (look)
            check({30'h0, secondIndicator, firstIndicator}, expQ.pop_front());
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        finish_test;
    end
    initial begin
        {rst_n, psel, penable, pwrite, look, clr, paddr, pwdata} = '0;
        {linkUp, speed100, fullDuplex, txActive, rxActive, collision} = 6'h10;
        clkEn = 1'b1;
        seed = 19;
        doReset;
        expQ.push_back(32'h0000_0422);
        apb(1'b0, `LSS_ADDR_CFG, 32'h0000_0000);
        lamps(2'b01);
        expQ.push_back(32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0000_0000);                  // unmapped read gives zero
        r = $random(seed);
        apb(1'b1, `LSS_ADDR_CFG, r);
        expQ.push_back({16'h0000, r[15:0] & `LSS_CFG_WMASK});
        apb(1'b0, `LSS_ADDR_CFG, 32'h0000_0000);
        $display("register test done");
        // every plain code on both lamps against random status
        foreach (codes[j]) begin
            f = (codes[j] == 4'h6) ? 4'h8 : codes[j];       // first lamp has no code 6
            apb(1'b1, `LSS_ADDR_CFG, {16'h0000, f, codes[j], 8'h00});
            repeat (3) begin
                r = $random(seed);
                {linkUp, speed100, fullDuplex, txActive, rxActive, collision} <= r[5:0];
                repeat (2) @(posedge mclk);
                lamps({lvl(codes[j]), lvl(f)});
            end
        end
        $display("source code test done");
        apb(1'b1, `LSS_ADDR_CFG, {16'h0000, `LSS_SRC_FAST, `LSS_SRC_SLOW, 8'h00});
        watch(64);
        check({31'h0, togA >= 16'h000f && togA <= 16'h0011}, YES);
        check({31'h0, togB >= 16'h0003 && togB <= 16'h0005}, YES);
        // reserved length with stretching on: a one cycle event must hold
        apb(1'b1, `LSS_ADDR_CFG, {16'h0000, `LSS_SRC_TX, `LSS_SRC_ON, 8'h0e});
        txActive <= 1'b1;
        @(posedge mclk);
        txActive <= 1'b0;
        repeat (40) @(posedge mclk);
        lamps(2'b11);
        $display("blink and stretch test done");
        // fresh reset so no earlier event is still being stretched
        doReset;
        {linkUp, speed100, fullDuplex, txActive, rxActive, collision} <= 6'h38;
        apb(1'b1, `LSS_ADDR_CFG, {16'h0000, `LSS_SRC_LINKACT, `LSS_SRC_LINKRX, 8'h00});
        watch(24);
        check({30'h0, togB == 16'h0000, togA == 16'h0000}, 32'h0000_0003);
        lamps(2'b11);
        apb(1'b1, `LSS_ADDR_CFG, {16'h0000, `LSS_SRC_LINKACT, `LSS_SRC_DUPCOL, 8'h00});
        watch(16);
        lamps(2'b11);
        collision <= 1'b1;
        @(posedge mclk);
        collision <= 1'b0;
        watch(32);
        check({31'h0, togB != 16'h0000}, YES);
        apb(1'b1, `LSS_ADDR_CFG, {16'h0000, `LSS_SRC_LINKACT, `LSS_SRC_LINKRX, 8'h00});
        {linkUp, txActive, rxActive} <= 3'h3;
        @(posedge mclk);
        {txActive, rxActive} <= 2'h0;
        watch(32);
        check({30'h0, togB != 16'h0000, togA != 16'h0000}, 32'h0000_0003);
        $display("combined mode test done");
        // a write while the clock enable is low must leave the register alone
        clkEn <= 1'b0;
        apb(1'b1, `LSS_ADDR_CFG, 32'h0000_8800);
        clkEn <= 1'b1;
        expQ.push_back(32'h0000_ec00);
        apb(1'b0, `LSS_ADDR_CFG, 32'h0000_0000);
        $display("clock enable test done");
        finish_test;
    end
endmodule // led_source_select_tb
